// *** dbg_defs.svh ***
// constants for the hart run-control debug block
`ifndef DBG_DEFS_SVH
`define DBG_DEFS_SVH

`define XLEN               32
`define CSR_ADDR_W         12
`define CSR_DCSR           12'h7B0
`define CSR_DPC            12'h7B1
`define CSR_DSCRATCH0      12'h7B2
`define CSR_DSCRATCH1      12'h7B3
`define CSR_TSELECT        12'h7A0
`define CSR_TRIG_FIRST     12'h7A1
`define CSR_TRIG_SECOND    12'h7A2
`define CSR_TINFO          12'h7A4

`define CAUSE_W            3
`define CAUSE_EBREAK       3'h1
`define CAUSE_TRIGGER      3'h2
`define CAUSE_HALTREQ      3'h3
`define DCSR_XDEBUGVER     4'h4
`define DCSR_PRV_M         2'h3
`define DCSR_BREAK_POS     15
`define DCSR_CAUSE_LSB     6
`define DCSR_XDEBUGVER_LSB 28
`define DCSR_PRV_LSB       0

`define TRIG_TYPE_MATCH    4'h2
`define TRIG_ACTION_DBG    4'h1
`define TRIG_EXEC_POS      2
`define TRIG_TYPE_LSB      28
`define TRIG_OWNER_POS     27
`define TRIG_ACTION_LSB    12
`define TRIG_MMODE_POS     6
`define TINFO_VALUE        32'h0000_0004

`define AXI_ADDR_W         4
`define REG_CTRL           4'h0
`define REG_STATUS         4'h4
`define REG_DPC            4'h8
`define REG_DCSR           4'hC
`define CTRL_HALT_POS      0
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// *** dbg_pkg.sv ***
// types shared by the hart run-control debug block
package dbg_pkg;
  typedef enum logic [1:0] {
    ST_UNAVAIL = 2'b00,
    ST_RUNNING = 2'b01,
    ST_HALTED  = 2'b10
  } run_state_e;
endpackage

// *** addr_match_trigger.sv ***
// single instruction-address-match trigger with its csr storage
`timescale 1ns/1ps
`include "dbg_defs.svh"
module addr_match_trigger (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   wr_en,
  input  wire logic [`CSR_ADDR_W-1:0] wr_addr,
  input  wire logic [`XLEN-1:0]       wr_data,
  input  wire logic [`CSR_ADDR_W-1:0] rd_addr,
  output logic      [`XLEN-1:0]       rd_data,
  input  wire logic                   dec_valid,
  input  wire logic [`XLEN-1:0]       dec_pc,
  output logic                        match
);
  logic             exec_en;
  logic [`XLEN-1:0] match_addr;
  logic [`XLEN-1:0] trigger_data_first;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_en    <= 1'b0;
      match_addr <= '0;
    end else if (wr_en) begin
      if (wr_addr == `CSR_TRIG_FIRST) begin
        exec_en <= wr_data[`TRIG_EXEC_POS];
      end
      if (wr_addr == `CSR_TRIG_SECOND) begin
        match_addr <= wr_data;
      end
    end
  end

  always_comb begin
    trigger_data_first = '0;
    trigger_data_first[`TRIG_TYPE_LSB +: 4] = `TRIG_TYPE_MATCH;
    trigger_data_first[`TRIG_OWNER_POS] = 1'b1;
    trigger_data_first[`TRIG_ACTION_LSB +: 4] = `TRIG_ACTION_DBG;
    trigger_data_first[`TRIG_MMODE_POS] = 1'b1;
    trigger_data_first[`TRIG_EXEC_POS] = exec_en;
  end

  always_comb begin
    unique case (rd_addr)
      `CSR_TRIG_FIRST:  rd_data = trigger_data_first;
      `CSR_TRIG_SECOND: rd_data = match_addr;
      `CSR_TINFO:       rd_data = `TINFO_VALUE;
      default:          rd_data = '0;
    endcase
  end

  assign match = exec_en & dec_valid & (dec_pc == match_addr);

  chk_owner_const: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_addr == `CSR_TRIG_FIRST) |-> rd_data[`TRIG_OWNER_POS]) else $error("ownership bit not one");
  chk_match_addr_write: assert property (@(posedge aclk) disable iff (!aresetn)
    !$stable(match_addr) |-> $past(wr_en)) else $error("match address changed without write");
endmodule

// *** axil_debug_regs.sv ***
// axi4-lite slave exposing debug control and state to software
`timescale 1ns/1ps
`include "dbg_defs.svh"
module axil_debug_regs (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [31:0]            status_word,
  input  wire logic [31:0]            dpc_word,
  input  wire logic [31:0]            dcsr_word,
  output logic                        soft_halt_pulse
);
  logic                   aw_got;
  logic                   w_got;
  logic [`AXI_ADDR_W-1:0] aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   do_write;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_got <= 1'b0;
      end
    end
  end

  // only ctrl is writable; other offsets answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= `RESP_OKAY;
      soft_halt_pulse <= 1'b0;
    end else begin
      soft_halt_pulse <= do_write && aw_addr == `REG_CTRL && w_strb[0] && w_data[`CTRL_HALT_POS];
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `REG_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      unique case (s_axi_araddr)
        `REG_CTRL:   s_axi_rdata <= '0;
        `REG_STATUS: s_axi_rdata <= status_word;
        `REG_DPC:    s_axi_rdata <= dpc_word;
        `REG_DCSR:   s_axi_rdata <= dcsr_word;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** hart_debug_run_control.sv ***
// run-control debug logic: halt entry, debug csrs, status outputs
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dbg_defs.svh"
module hart_debug_run_control
  import dbg_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   fetch_enable_in,
  input  wire logic                   debug_req,
  input  wire logic [`XLEN-1:0]       halt_entry_address_in,
  input  wire logic [`XLEN-1:0]       debug_exception_address_in,
  input  wire logic [`XLEN-1:0]       boot_address_in,
  input  wire logic                   dec_valid,
  input  wire logic [`XLEN-1:0]       dec_pc,
  input  wire logic                   dec_is_ebreak,
  input  wire logic                   dec_is_dret,
  input  wire logic                   dec_is_xret,
  input  wire logic                   dec_exception,
  input  wire logic                   dec_csr_access,
  input  wire logic                   dec_csr_write,
  input  wire logic [`CSR_ADDR_W-1:0] dec_csr_addr,
  input  wire logic [`XLEN-1:0]       dec_csr_wdata,
  output logic                        kill_decode,
  output logic                        pc_set,
  output logic      [`XLEN-1:0]       pc_target,
  output logic                        illegal_instr,
  output logic                        ebreak_exception,
  output logic      [`XLEN-1:0]       csr_rdata,
  output logic                        debug_mode,
  output logic                        debug_have_reset,
  output logic                        debug_running,
  output logic                        debug_halted,
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  run_state_e             state;
  logic                   fe_meta;
  logic                   fe_sync;
  logic                   req_seen;
  logic                   soft_pend;
  logic                   soft_halt_pulse;
  logic                   break_to_debug_bit;
  logic [`CAUSE_W-1:0]    dcause;
  logic [`XLEN-1:0]       dpc;
  logic [`XLEN-1:0]       dscratch0;
  logic [`XLEN-1:0]       dscratch1;
  logic [`XLEN-1:0]       dcsr_word;
  logic [`XLEN-1:0]       trig_rdata;
  logic                   trig_match;
  logic                   live;
  logic                   halt_ask;
  logic                   enter_trig;
  logic                   enter_ebrk;
  logic                   enter_halt;
  logic                   entry;
  logic                   first_halt;
  logic                   dbg_ebrk;
  logic                   dbg_exc;
  logic                   dbg_ret;
  logic                   is_dbg_csr;
  logic                   is_trig_csr;
  logic                   csr_we;
  logic [`CAUSE_W-1:0]    next_cause;

  // fetch enable is a pin: two flops before anything looks at it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fe_meta <= 1'b0;
      fe_sync <= 1'b0;
    end else begin
      fe_meta <= fetch_enable_in;
      fe_sync <= fe_meta;
    end
  end

  assign live     = (state == ST_RUNNING);
  // request taken as a same-clock level
  assign halt_ask = debug_req | soft_pend;

  assign enter_trig = live & trig_match;
  assign enter_ebrk = live & dec_valid & dec_is_ebreak & break_to_debug_bit;
  assign enter_halt = live & halt_ask;
  assign entry      = enter_trig | enter_ebrk | enter_halt;
  // pending request skips the running state
  assign first_halt = (state == ST_UNAVAIL) & fe_sync & (req_seen | halt_ask);

  assign dbg_ebrk = debug_mode & dec_valid & dec_is_ebreak;
  assign dbg_exc  = debug_mode & dec_valid & (dec_exception | dec_is_xret);
  assign dbg_ret  = debug_mode & dec_valid & dec_is_dret & !dbg_exc;

  assign kill_decode = entry;

  // trigger cause outranks ebreak, which outranks a halt request
  always_comb begin
    if (enter_trig) begin
      next_cause = `CAUSE_TRIGGER;
    end else if (enter_ebrk) begin
      next_cause = `CAUSE_EBREAK;
    end else begin
      next_cause = `CAUSE_HALTREQ;
    end
  end

  // addresses used as given, alignment is the integrator's duty
  always_comb begin
    pc_set    = 1'b1;
    pc_target = halt_entry_address_in;
    if (entry || first_halt) begin
      pc_target = halt_entry_address_in;
    end else if (dbg_ebrk) begin
      pc_target = halt_entry_address_in;
    end else if (dbg_exc) begin
      pc_target = debug_exception_address_in;
    end else if (dbg_ret) begin
      pc_target = dpc;
    end else begin
      pc_set = 1'b0;
    end
  end

  assign is_dbg_csr  = dec_csr_addr >= `CSR_DCSR && dec_csr_addr <= `CSR_DSCRATCH1;
  assign is_trig_csr = dec_csr_addr >= `CSR_TSELECT && dec_csr_addr <= `CSR_TINFO;
  // trigger writes only take effect in debug mode
  assign csr_we = debug_mode & dec_valid & dec_csr_write & !dbg_exc;

  // debug csr access or dret in the running state; nothing else flagged here
  assign illegal_instr = live & !entry & dec_valid & ((dec_csr_access & is_dbg_csr) | dec_is_dret);
  // ebreak with bit clear goes the ordinary way
  assign ebreak_exception = live & !entry & dec_valid & dec_is_ebreak & !break_to_debug_bit;

  // status held during reset; one-hot kept by gating with reset
  assign debug_have_reset = !aresetn | (state == ST_UNAVAIL);
  // status decoded from the run state
  assign debug_running    = aresetn & (state == ST_RUNNING);
  assign debug_halted     = aresetn & (state == ST_HALTED);

  // unavailable until synced fetch enable; halt taken at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= ST_UNAVAIL;
      debug_mode <= 1'b0;
    end else begin
      unique case (state)
        ST_UNAVAIL: begin
          if (first_halt) begin
            state      <= ST_HALTED;
            debug_mode <= 1'b1;
          end else if (fe_sync) begin
            state <= ST_RUNNING;
          end
        end
        ST_RUNNING: begin
          if (entry) begin
            state      <= ST_HALTED;
            debug_mode <= 1'b1;
          end
        end
        ST_HALTED: begin
          if (dbg_ret) begin
            state      <= ST_RUNNING;
            debug_mode <= 1'b0;
          end
        end
        default: begin
          state      <= ST_UNAVAIL;
          debug_mode <= 1'b0;
        end
      endcase
    end
  end

  // requests seen while unavailable; for soft_pend set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_seen  <= 1'b0;
      soft_pend <= 1'b0;
    end else begin
      req_seen  <= (state == ST_UNAVAIL) & (req_seen | debug_req);
      soft_pend <= soft_halt_pulse | (soft_pend & !(entry | first_halt | debug_mode));
    end
  end

  // save pc and cause on entry, boot address on first halt; dpc also writable in debug mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dpc    <= '0;
      dcause <= '0;
    end else if (entry) begin
      dpc    <= dec_pc;
      dcause <= next_cause;
    end else if (first_halt) begin
      dpc    <= boot_address_in;
      dcause <= `CAUSE_HALTREQ;
    end else if (csr_we && dec_csr_addr == `CSR_DPC) begin
      dpc <= dec_csr_wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_to_debug_bit <= 1'b0;
      dscratch0          <= '0;
      dscratch1          <= '0;
    end else if (csr_we) begin
      unique case (dec_csr_addr)
        `CSR_DCSR:      break_to_debug_bit <= dec_csr_wdata[`DCSR_BREAK_POS];
        `CSR_DSCRATCH0: dscratch0 <= dec_csr_wdata;
        `CSR_DSCRATCH1: dscratch1 <= dec_csr_wdata;
        default:        ;
      endcase
    end
  end

  always_comb begin
    dcsr_word = '0;
    dcsr_word[`DCSR_XDEBUGVER_LSB +: 4] = `DCSR_XDEBUGVER;
    dcsr_word[`DCSR_BREAK_POS] = break_to_debug_bit;
    dcsr_word[`DCSR_CAUSE_LSB +: `CAUSE_W] = dcause;
    dcsr_word[`DCSR_PRV_LSB +: 2] = `DCSR_PRV_M;
  end

  // debug code moves registers through these csr reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_rdata <= '0;
    end else if (dec_valid && dec_csr_access && (debug_mode || !is_dbg_csr)) begin
      unique case (dec_csr_addr)
        `CSR_DCSR:      csr_rdata <= dcsr_word;
        `CSR_DPC:       csr_rdata <= dpc;
        `CSR_DSCRATCH0: csr_rdata <= dscratch0;
        `CSR_DSCRATCH1: csr_rdata <= dscratch1;
        default:        csr_rdata <= is_trig_csr ? trig_rdata : '0;
      endcase
    end
  end

  addr_match_trigger u_trigger (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_en     (csr_we & is_trig_csr),
    .wr_addr   (dec_csr_addr),
    .wr_data   (dec_csr_wdata),
    .rd_addr   (dec_csr_addr),
    .rd_data   (trig_rdata),
    .dec_valid (dec_valid),
    .dec_pc    (dec_pc),
    .match     (trig_match)
  );

  axil_debug_regs u_regs (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .s_axi_awaddr    (s_axi_awaddr),
    .s_axi_awvalid   (s_axi_awvalid),
    .s_axi_awready   (s_axi_awready),
    .s_axi_wdata     (s_axi_wdata),
    .s_axi_wstrb     (s_axi_wstrb),
    .s_axi_wvalid    (s_axi_wvalid),
    .s_axi_wready    (s_axi_wready),
    .s_axi_bresp     (s_axi_bresp),
    .s_axi_bvalid    (s_axi_bvalid),
    .s_axi_bready    (s_axi_bready),
    .s_axi_araddr    (s_axi_araddr),
    .s_axi_arvalid   (s_axi_arvalid),
    .s_axi_arready   (s_axi_arready),
    .s_axi_rdata     (s_axi_rdata),
    .s_axi_rresp     (s_axi_rresp),
    .s_axi_rvalid    (s_axi_rvalid),
    .s_axi_rready    (s_axi_rready),
    .status_word     ({27'h0, break_to_debug_bit, soft_pend, debug_mode, state}),
    .dpc_word        (dpc),
    .dcsr_word       (dcsr_word),
    .soft_halt_pulse (soft_halt_pulse)
  );

  sequence s_dret_taken;
    debug_mode && dec_valid && dec_is_dret && !dec_exception && !dec_is_xret;
  endsequence
  sequence s_back_running;
    !debug_mode && debug_running && !debug_halted;
  endsequence

  chk_status_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot({debug_have_reset, debug_running, debug_halted})) else $error("status not one-hot");
  chk_entry_saves_pc: assert property (@(posedge aclk) disable iff (!aresetn)
    entry |-> pc_set && pc_target == halt_entry_address_in ##1 dpc == $past(dec_pc) && debug_halted)
    else $error("entry did not save pc or jump");
  chk_halt_req_kill: assert property (@(posedge aclk) disable iff (!aresetn)
    (debug_running && debug_req) |-> kill_decode) else $error("halt request did not squash decode");
  chk_direct_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    (debug_have_reset && req_seen) |=> !debug_running) else $error("passed through running");
  chk_ebreak_rejump: assert property (@(posedge aclk) disable iff (!aresetn)
    dbg_ebrk |-> pc_target == halt_entry_address_in ##1 $stable(dcsr_word) && $stable(dpc))
    else $error("debug ebreak misbehaved");
  chk_xret_redirect: assert property (@(posedge aclk) disable iff (!aresetn)
    (debug_mode && dec_valid && dec_is_xret) |-> pc_set && pc_target == debug_exception_address_in)
    else $error("xret in debug not redirected");
  chk_illegal_access: assert property (@(posedge aclk) disable iff (!aresetn)
    (debug_running && dec_valid && dec_csr_access && is_dbg_csr && !entry) |-> illegal_instr)
    else $error("debug csr access not illegal");
  chk_ebreak_ordinary: assert property (@(posedge aclk) disable iff (!aresetn)
    (debug_running && dec_valid && dec_is_ebreak && !break_to_debug_bit && !halt_ask && !trig_match)
    |-> ebreak_exception && !kill_decode) else $error("ebreak did not take exception path");
  chk_dret_resume: assert property (@(posedge aclk) disable iff (!aresetn)
    s_dret_taken |-> pc_target == dpc ##1 s_back_running) else $error("debug return failed");
  chk_trig_write_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !debug_mode |-> !(csr_we && is_trig_csr)) else $error("trigger write outside debug mode");
endmodule

// *** dbg_module_model.sv ***
// stand-in for the external debug module that raises halt requests
`timescale 1ns/1ps
module dbg_module_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic go,
  input  wire logic debug_halted,
  output logic      debug_req
);
  // synchronous request, held
  // held until halted is seen, so never shorter than one full period
  always_ff @(posedge aclk) begin
    if (!aresetn)
      debug_req <= 1'h0;
    else if (go)
      debug_req <= 1'h1;
    else if (debug_halted)
      debug_req <= 1'h0;
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the hart run-control debug block
`timescale 1ns/1ps
`include "dbg_defs.svh"
module testbench;
  import dbg_pkg::*;
  logic        aclk = 0, aresetn = 0, fetch_enable_in = 0, debug_req, go = 0, dec_valid = 0;
  logic        dec_is_ebreak = 0, dec_is_dret = 0, dec_is_xret = 0, dec_exception = 0, dec_csr_write = 0;
  logic        dec_csr_access = 0, kill_decode, pc_set, illegal_instr, ebreak_exception, debug_mode;
  logic        debug_have_reset, debug_running, debug_halted, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] dec_csr_addr = 0;
  logic [31:0] dec_pc = 0, dec_csr_wdata = 0, pc_target, csr_rdata, rd, s_axi_wdata = 0, s_axi_rdata;
  logic [31:0] halt_entry_address_in = 32'h800, debug_exception_address_in = 32'h808;
  logic [31:0] boot_address_in = 32'h100;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          bad_count = 0, cmp_count = 0, n;
  always #10 aclk = ~aclk;
  hart_debug_run_control i_hart_debug_run_control (.aclk, .aresetn, .fetch_enable_in, .debug_req,
    .halt_entry_address_in, .debug_exception_address_in, .boot_address_in, .dec_valid, .dec_pc,
    .dec_is_ebreak, .dec_is_dret, .dec_is_xret, .dec_exception, .dec_csr_access, .dec_csr_write,
    .dec_csr_addr, .dec_csr_wdata, .kill_decode, .pc_set, .pc_target, .illegal_instr, .ebreak_exception,
    .csr_rdata, .debug_mode, .debug_have_reset, .debug_running, .debug_halted, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dbg_module_model i_dbg_module_model (.aclk, .aresetn, .go, .debug_halted, .debug_req);
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one access; handshakes judged on values settled before each edge
  task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
      rs = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (ta) s_axi_arvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) break;
    end
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    if (n == 40) begin
      ck("axi wait", 0, 1);
      end_of_test();
    end
  endtask
  task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    dec_valid <= 1;
    dec_is_dret <= 0;
    dec_is_ebreak <= 0;
    dec_csr_access <= 1;
    dec_csr_write <= w;
    dec_csr_addr <= a;
    dec_csr_wdata <= d;
  endtask
  task automatic step(input logic r, input logic b, input logic [31:0] p);
    @(posedge aclk);
    dec_valid <= 1;
    dec_csr_access <= 0;
    dec_csr_write <= 0;
    dec_is_dret <= r;
    dec_is_ebreak <= b;
    dec_pc <= p;
    #1;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    #1;
    ck("have_reset", 1, debug_have_reset);
    ck("run_halt", 0, {debug_running, debug_halted});
    @(posedge aclk);
    aresetn <= 1;
    go <= 1;
    @(posedge aclk);
    go <= 0;
    fetch_enable_in <= 1;
    for (n = 0; n < 20 && debug_halted !== 1'h1; n++) begin
      @(posedge aclk);
      #1;
      ck("running", 0, debug_running);
      ck("onehot", 1, $onehot({debug_have_reset, debug_running, debug_halted}));
    end
    ck("halted", 1, debug_halted);
    axi(0, `REG_DPC, 0);
    ck("dpc", boot_address_in, rd);
    axi(0, `REG_DCSR, 0);
    ck("cause", `CAUSE_HALTREQ, rd[`DCSR_CAUSE_LSB +: `CAUSE_W]);
    axi(0, `REG_STATUS, 0);
    ck("status", 5'h06, rd[4:0]);
    axi(1, `REG_STATUS, 0);
    ck("bresp", `RESP_SLVERR, rs);
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      dec_valid <= 1;
      dec_is_ebreak <= i == 0;
      dec_is_xret <= i == 1;
      dec_exception <= i == 2;
      #1;
      ck("target", i == 0 ? halt_entry_address_in : debug_exception_address_in, pc_target);
    end
    @(posedge aclk);
    dec_exception <= 0;
    dec_csr_access <= 1;
    dec_csr_addr <= `CSR_TRIG_FIRST;
    @(posedge aclk);
    dec_csr_addr <= `CSR_DCSR;
    #1;
    ck("illegal dbg", 0, illegal_instr);
    ck("owner bit", 1, csr_rdata[`TRIG_OWNER_POS]);
    @(posedge aclk);
    dec_csr_access <= 0;
    dec_is_dret <= 1;
    #1;
    ck("dret target", boot_address_in, pc_target);
    @(posedge aclk);
    dec_is_dret <= 0;
    dec_csr_access <= 1;
    #1;
    ck("running", 1, debug_running);
    ck("illegal run", 1, illegal_instr);
    @(posedge aclk);
    dec_csr_access <= 0;
    dec_is_ebreak <= 1;
    #1;
    ck("ebreak trap", 1, ebreak_exception);
    @(posedge aclk);
    dec_is_ebreak <= 0;
    dec_pc <= 32'h240;
    go <= 1;
    #1;
    ck("halted", 0, debug_halted);
    @(posedge aclk);
    go <= 0;
    #1;
    ck("kill", 1, kill_decode);
    ck("entry", halt_entry_address_in, pc_target);
    @(posedge aclk);
    dec_valid <= 0;
    #1;
    ck("halted", 1, debug_halted);
    axi(0, `REG_DPC, 0);
    ck("dpc", 32'h240, rd);
    csr(1, `CSR_TRIG_SECOND, 32'h300);
    csr(1, `CSR_TRIG_FIRST, 32'h1 << `TRIG_EXEC_POS);
    csr(1, `CSR_DCSR, 32'h1 << `DCSR_BREAK_POS);
    csr(0, `CSR_TRIG_SECOND, 0);
    step(1, 0, 32'h200);
    ck("trigger addr", 32'h300, csr_rdata);
    ck("pc_set", 1, pc_set);
    csr(1, `CSR_TRIG_SECOND, 32'h500);
    #1;
    ck("debug_mode", 0, debug_mode);
    csr(0, `CSR_TRIG_SECOND, 0);
    step(0, 0, 32'h300);
    ck("trigger kept", 32'h300, csr_rdata);
    ck("trigger kill", 1, kill_decode);
    axi(0, `REG_DCSR, 0);
    ck("trigger cause", `CAUSE_TRIGGER, rd[`DCSR_CAUSE_LSB +: `CAUSE_W]);
    ck("break bit", 1, rd[`DCSR_BREAK_POS]);
    step(1, 0, 32'h200);
    step(0, 1, 32'h200);
    ck("ebreak entry", 1, kill_decode);
    ck("no trap", 0, ebreak_exception);
    step(0, 0, 32'h200);
    ck("halted", 1, debug_halted);
    axi(0, `REG_DCSR, 0);
    ck("ebreak cause", `CAUSE_EBREAK, rd[`DCSR_CAUSE_LSB +: `CAUSE_W]);
    step(1, 0, 32'h200);
    step(0, 0, 32'h200);
    ck("running", 1, debug_running);
    axi(1, `REG_CTRL, 32'h1);
    ck("ctrl bresp", `RESP_OKAY, rs);
    @(posedge aclk);
    #1;
    ck("soft halted", 1, debug_halted);
    ck("debug_mode", 1, debug_mode);
    end_of_test();
  end
endmodule
